// ==== tpd_pkg.sv ====
package tpd_pkg;

   // ==========================================================
   // register offsets
   localparam logic [7:0] ADDR_CLK_SEL = 8'h26;
   localparam logic [7:0] ADDR_PIN_FUNC = 8'h27;
   localparam logic [7:0] ADDR_TIMER3_CTRL = 8'h28;
   localparam logic [7:0] ADDR_DUTY_CH0 = 8'h44;
   localparam logic [7:0] ADDR_DUTY_CH1 = 8'h45;
   localparam logic [7:0] ADDR_DUTY_CH2 = 8'h46;

   // ==========================================================
   // field positions
   localparam int CTRL_CLEAR_BIT = 0;
   localparam int CTRL_RUN_BIT = 1;
   localparam int CTRL_MODE_BIT = 3;
   localparam int CLK_RATE_BIT = 0;
   localparam int CLK_WIDTH_BIT = 2;

   // ==========================================================
   // reset values
   localparam logic [8:0] DUTY_RESET = 9'h1ff;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam logic [2:0] PIN_FUNC_RESET = 3'h0;

   // ==========================================================
   // timing: core clock and the two basic clock rates
   localparam int CORE_CLK_KHZ = 200000;
   localparam int FAST_RATE_HZ = 1125000;
   localparam int SLOW_DIV = 10;
   localparam int FAST_DIV_CYCLES = (CORE_CLK_KHZ * 1000) / FAST_RATE_HZ;
   localparam int SLOW_DIV_CYCLES = FAST_DIV_CYCLES * SLOW_DIV;
   // quarter-count divisor: high for one quarter of a basic period at count == duty
   localparam int QUARTER_DIV = 4;

   // ==========================================================
   // carried types
   typedef enum logic [1:0] {
      TPD_XFER_NONE = 2'b00,
      TPD_XFER_WRITE = 2'b01,
      TPD_XFER_READ = 2'b10
   } tpd_xfer_e;

   typedef struct packed {
      tpd_xfer_e kind;
      logic [7:0] addr;
      logic [15:0] data;
   } tpd_xfer_s;

endpackage

// ==== tpd_tick_gen.sv ====
`timescale 1ns/1ps
// ==========================================================
// basic clock generator: one-cycle ticks at fast or slow rate
module tpd_tick_gen #(
   parameter int FAST_DIV = tpd_pkg::FAST_DIV_CYCLES,
   parameter int SLOW_DIV = tpd_pkg::SLOW_DIV_CYCLES
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // control
   input wire logic rate_sel_in,
   // ticks
   output logic tick_out,
   output logic quarter_out
);
   logic [15:0] cnt_q, cnt_d;
   logic tick_q, tick_d;
   logic quarter_q, quarter_d;
   logic [15:0] last;

   // the quarter window needs at least four core cycles per count
   if (FAST_DIV < 4 || SLOW_DIV < FAST_DIV ||
       SLOW_DIV > 65535) begin : g_bad_div
      $error("tpd_tick_gen: divider out of range");
   end

   // divider next state; a rate change applies to the current period at once
   always_comb begin
      last = rate_sel_in ? 16'(SLOW_DIV - 1) : 16'(FAST_DIV - 1);
      cnt_d = (cnt_q >= last) ? 16'h0000 : cnt_q + 16'h0001;
      tick_d = (cnt_q >= last);
      // quarter window marks the first quarter of each basic period;
      // taken from the old count so the pulse never splits across a tick
      quarter_d = (cnt_q < 16'((32'(last) + 32'd1) / tpd_pkg::QUARTER_DIV));
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         cnt_q <= 16'h0000;
         tick_q <= 1'b0;
         quarter_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
         quarter_q <= quarter_d;
      end
   end

   assign tick_out = tick_q;
   assign quarter_out = quarter_q;
endmodule

// ==== tpd_channel.sv ====
`timescale 1ns/1ps
// ==========================================================
// one pwm comparator with its own phase-shifted counter
module tpd_channel #(
   parameter logic [8:0] PHASE = 9'h000
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // shared timing
   input wire logic tick_in,
   input wire logic quarter_in,
   input wire logic width9_in,
   input wire logic counter_clear_in,
   // duty
   input wire logic [8:0] duty_in,
   // result
   output logic pwm_out
);
   logic [8:0] cnt_q, cnt_d;
   logic [8:0] cmp_cnt;
   logic [8:0] cmp_duty;

   // free-running 9-bit counter, wraps at 512; the 8-bit compare sees a 256 period
   always_comb begin
      cnt_d = cnt_q;
      if (counter_clear_in)
         cnt_d = PHASE;
      else if (tick_in)
         cnt_d = cnt_q + 9'h001;
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in)
         cnt_q <= PHASE;
      else
         cnt_q <= cnt_d;
   end

   // compare on 8 or 9 bits; equal gives the quarter-count pulse
   always_comb begin
      cmp_cnt = width9_in ? cnt_q : {1'b0, cnt_q[7:0]};
      cmp_duty = width9_in ? duty_in : {1'b0, duty_in[7:0]};
      pwm_out = (cmp_duty > cmp_cnt) ||
                ((cmp_duty == cmp_cnt) && quarter_in);
   end
endmodule

// ==== tpd_pwm_dac.sv ====
`timescale 1ns/1ps
module tpd_pwm_dac #(
   parameter int FAST_DIV = tpd_pkg::FAST_DIV_CYCLES,
   parameter int SLOW_DIV = tpd_pkg::SLOW_DIV_CYCLES
) (
   // clock and power-on / watchdog reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // system conditions
   input wire logic ce_reset_in,
   input wire logic halt_in,
   input wire logic clock_stop_in,
   // transfer port
   input wire tpd_pkg::tpd_xfer_s xfer_in,
   output logic [15:0] transfer_buffer_out,
   // general-purpose output latch values
   input wire logic [2:0] port_latch_in,
   // open-drain pins
   output logic out_pin_0_out,
   output logic out_pin_0_oe_out,
   output logic out_pin_1_out,
   output logic out_pin_1_oe_out,
   output logic out_pin_2_out,
   output logic out_pin_2_oe_out,
   // timer 3 view
   output logic timer_mode_select_out,
   output logic counter_run_out,
   output logic [8:0] modulo_out
);
   // ==========================================================
   // register state
   logic [8:0] duty_q [3];
   logic [8:0] duty_d [3];
   logic timer_mode_select_q, timer_mode_select_d;
   logic counter_run_q, counter_run_d;
   logic counter_clear_q, counter_clear_d;
   logic [2:0] pin_func_q, pin_func_d;
   logic counter_width_sel_q, counter_width_sel_d;
   logic rate_sel_q, rate_sel_d;
   logic [15:0] rd_q, rd_d;
   logic [2:0] pin_q, pin_d;
   logic [2:0] oe_q, oe_d;
   logic [8:0] modulo_q, modulo_d;

   // ==========================================================
   // parameter check
   // dividers under four core cycles leave no room for the quarter
   if (FAST_DIV < tpd_pkg::QUARTER_DIV || SLOW_DIV < FAST_DIV ||
       SLOW_DIV > 65535) begin : g_bad_div
      $error("tpd_pwm_dac: divider settings out of range");
   end

   // ==========================================================
   // shared timing and channels
   logic tick;
   logic quarter;
   logic [2:0] pwm;
   logic is_wr;
   logic is_rd;
   logic [8:0] wr_duty;

   // one basic clock for all channels
   // shared basic clock
   tpd_tick_gen #(
      .FAST_DIV(FAST_DIV),
      .SLOW_DIV(SLOW_DIV)
   ) u_tick (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .rate_sel_in(rate_sel_q),
      .tick_out(tick),
      .quarter_out(quarter)
   );

   // phases spread by a third of the 8-bit period
   // staggered channel phases
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_ch
         tpd_channel #(
            .PHASE(9'(gi * 85))
         ) u_ch (
            .core_clk_in(core_clk_in),
            .rst_in(rst_in),
            .tick_in(tick),
            .quarter_in(quarter),
            .width9_in(counter_width_sel_q),
            .counter_clear_in(counter_clear_q),
            .duty_in(duty_q[gi]),
            .pwm_out(pwm[gi])
         );
      end
   endgenerate

   // ==========================================================
   // transfer decode
   always_comb begin
      is_wr = (xfer_in.kind == tpd_pkg::TPD_XFER_WRITE);
      is_rd = (xfer_in.kind == tpd_pkg::TPD_XFER_READ);
      wr_duty = xfer_in.data[8:0];
   end

   // ==========================================================
   // control registers next state
   always_comb begin
      timer_mode_select_d = timer_mode_select_q;
      counter_run_d = counter_run_q;
      counter_clear_d = 1'b0;
      pin_func_d = pin_func_q;
      counter_width_sel_d = counter_width_sel_q;
      rate_sel_d = rate_sel_q;
      if (is_wr) begin
         unique case (xfer_in.addr)
            tpd_pkg::ADDR_TIMER3_CTRL: begin
               timer_mode_select_d = xfer_in.data[tpd_pkg::CTRL_MODE_BIT];
               counter_run_d = xfer_in.data[tpd_pkg::CTRL_RUN_BIT];
               counter_clear_d = xfer_in.data[tpd_pkg::CTRL_CLEAR_BIT];
            end
            tpd_pkg::ADDR_PIN_FUNC: begin
               pin_func_d = xfer_in.data[2:0];
            end
            tpd_pkg::ADDR_CLK_SEL: begin
               counter_width_sel_d = xfer_in.data[tpd_pkg::CLK_WIDTH_BIT];
               rate_sel_d = xfer_in.data[tpd_pkg::CLK_RATE_BIT];
            end
            default: ;
         endcase
      end
      // clock stop drops pins back to port mode; ce reset/halt keep all
      // ce reset retains
      if (clock_stop_in) begin
         pin_func_d = tpd_pkg::PIN_FUNC_RESET;
         counter_width_sel_d = 1'b0;
         rate_sel_d = 1'b0;
         timer_mode_select_d = 1'b0;
         counter_run_d = 1'b0;
      end
   end

   // ==========================================================
   // duty registers next state
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         duty_d[i] = duty_q[i];
      end
      if (is_wr) begin
         unique case (xfer_in.addr)
            tpd_pkg::ADDR_DUTY_CH0:
               duty_d[0] = timer_mode_select_q ? {1'b0, wr_duty[7:0]}
                                               : wr_duty;
            tpd_pkg::ADDR_DUTY_CH1:
               duty_d[1] = timer_mode_select_q ? {1'b0, wr_duty[7:0]}
                                               : wr_duty;
            tpd_pkg::ADDR_DUTY_CH2:
               duty_d[2] = wr_duty;
            default: ;
         endcase
      end
      if (clock_stop_in) begin
         for (int i = 0; i < 3; i++) begin
            duty_d[i] = tpd_pkg::DUTY_RESET;
         end
      end
      modulo_d = duty_d[2];
   end

   // ==========================================================
   // read transfer next state
   always_comb begin
      rd_d = rd_q;
      if (is_rd) begin
         unique case (xfer_in.addr)
            tpd_pkg::ADDR_DUTY_CH0: rd_d = {7'h00, duty_q[0]};
            tpd_pkg::ADDR_DUTY_CH1: rd_d = {7'h00, duty_q[1]};
            tpd_pkg::ADDR_DUTY_CH2: rd_d = {7'h00, duty_q[2]};
            tpd_pkg::ADDR_TIMER3_CTRL:
               rd_d = {12'h000, timer_mode_select_q, 1'b0,
                       counter_run_q, 1'b0};
            tpd_pkg::ADDR_PIN_FUNC: rd_d = {13'h0000, pin_func_q};
            tpd_pkg::ADDR_CLK_SEL:
               rd_d = {13'h0000, counter_width_sel_q, 1'b0, rate_sel_q};
            default: rd_d = 16'h0000;
         endcase
      end
   end

   // ==========================================================
   // pin drive next state
   always_comb begin
      pin_d = pin_q;
      oe_d = oe_q;
      for (int i = 0; i < 3; i++) begin
         if (pin_func_d[i] && !timer_mode_select_d)
            pin_d[i] = pwm[i];
         else
            pin_d[i] = port_latch_in[i];
         // open drain: drive only when pulling low
         oe_d[i] = ~pin_d[i];
      end
   end

   // ==========================================================
   // control registers
   // control power-on defaults
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         timer_mode_select_q <= tpd_pkg::CTRL_RESET[tpd_pkg::CTRL_MODE_BIT];
         counter_run_q <= tpd_pkg::CTRL_RESET[tpd_pkg::CTRL_RUN_BIT];
         counter_clear_q <= 1'b0;
         pin_func_q <= tpd_pkg::PIN_FUNC_RESET;
         counter_width_sel_q <= 1'b0;
         rate_sel_q <= 1'b0;
      end else begin
         timer_mode_select_q <= timer_mode_select_d;
         counter_run_q <= counter_run_d;
         counter_clear_q <= counter_clear_d;
         pin_func_q <= pin_func_d;
         counter_width_sel_q <= counter_width_sel_d;
         rate_sel_q <= rate_sel_d;
      end
   end

   // ==========================================================
   // duty registers; modulo is a registered copy of channel 2
   // duties all ones
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         for (int i = 0; i < 3; i++) begin
            duty_q[i] <= tpd_pkg::DUTY_RESET;
         end
         modulo_q <= tpd_pkg::DUTY_RESET;
      end else begin
         for (int i = 0; i < 3; i++) begin
            duty_q[i] <= duty_d[i];
         end
         modulo_q <= modulo_d;
      end
   end

   // ==========================================================
   // read buffer, holds until the next read
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         rd_q <= 16'h0000;
      end else begin
         rd_q <= rd_d;
      end
   end

   // ==========================================================
   // pin drive; open drain pulls every pin low from reset
   // pins driven low
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         pin_q <= 3'h0;
         oe_q <= 3'h7;
      end else begin
         pin_q <= pin_d;
         oe_q <= oe_d;
      end
   end

   // ==========================================================
   // outputs, all from flops
   assign transfer_buffer_out = rd_q;
   assign out_pin_0_out = pin_q[0];
   assign out_pin_1_out = pin_q[1];
   assign out_pin_2_out = pin_q[2];
   assign out_pin_0_oe_out = oe_q[0];
   assign out_pin_1_oe_out = oe_q[1];
   assign out_pin_2_oe_out = oe_q[2];
   assign timer_mode_select_out = timer_mode_select_q;
   assign counter_run_out = counter_run_q;
   assign modulo_out = modulo_q;
endmodule

// ==== tpd_checker.sv ====
`timescale 1ns/1ps
// ==========================================================
// port checker for the pwm dac block
module tpd_checker (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // inputs watched
   input wire logic clock_stop_in,
   input wire tpd_pkg::tpd_xfer_s xfer_in,
   input wire logic [2:0] port_latch_in,
   // outputs watched
   input wire logic [15:0] transfer_buffer_out,
   input wire logic out_pin_0_out,
   input wire logic out_pin_0_oe_out,
   input wire logic out_pin_1_out,
   input wire logic out_pin_2_out,
   input wire logic timer_mode_select_out,
   input wire logic counter_run_out,
   input wire logic [8:0] modulo_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   // decoded requests
   wire logic [2:0] pins = {out_pin_2_out, out_pin_1_out, out_pin_0_out};
   wire logic rd = xfer_in.kind == tpd_pkg::TPD_XFER_READ;
   wire logic wr = xfer_in.kind == tpd_pkg::TPD_XFER_WRITE && !clock_stop_in;
   wire logic [7:0] ad = xfer_in.addr;
   // clock stop held two cycles; the pins show the latch from the first edge
   sequence s_stop_held;
      clock_stop_in [*2];
   endsequence
   // reset checks must run while reset is high, so no disable
   a_reset_pins_low: assert property (disable iff (1'b0)
      rst_in |=> pins == 3'h0 && out_pin_0_oe_out)
      else $error("pins not driven low after reset");
   a_reset_modulo_ones: assert property (disable iff (1'b0)
      rst_in |=> modulo_out == 9'h1ff) else $error("modulo not all ones");
   a_reset_control_zero: assert property (disable iff (1'b0)
      rst_in |=> !timer_mode_select_out && !counter_run_out)
      else $error("control not cleared by reset");
   a_stop_duty_ones: assert property (
      clock_stop_in |=> modulo_out == 9'h1ff)
      else $error("modulo not all ones on clock stop");
   a_stop_pins_latch: assert property (
      s_stop_held |=> pins == $past(port_latch_in))
      else $error("pins not from latch on clock stop");
   a_timer_pins_latch: assert property (
      timer_mode_select_out |-> pins == $past(port_latch_in))
      else $error("timer mode did not force port output");
   a_ctrl_write_bits: assert property (
      wr && ad == tpd_pkg::ADDR_TIMER3_CTRL |=>
      timer_mode_select_out == $past(xfer_in.data[3]) &&
      counter_run_out == $past(xfer_in.data[1]))
      else $error("control bits not written");
   a_modulo_write_shared: assert property (
      wr && ad == tpd_pkg::ADDR_DUTY_CH2 |=>
      modulo_out == $past(xfer_in.data[8:0]))
      else $error("modulo does not follow duty 2");
   a_read_modulo_back: assert property (
      rd && ad == tpd_pkg::ADDR_DUTY_CH2 && !clock_stop_in |=>
      transfer_buffer_out == {7'h0, modulo_out})
      else $error("read of duty 2 wrong");
   a_read_unmapped_zero: assert property (
      rd && !(ad inside {[8'h26:8'h28], [8'h44:8'h46]}) |=>
      transfer_buffer_out == 16'h0) else $error("unmapped read not zero");
   a_buffer_holds_value: assert property (
      !rd |=> $stable(transfer_buffer_out))
      else $error("buffer changed without read");
endmodule

bind tpd_pwm_dac tpd_checker tpd_checker_inst (
   .core_clk_in(core_clk_in), .rst_in(rst_in),
   .clock_stop_in(clock_stop_in), .xfer_in(xfer_in),
   .port_latch_in(port_latch_in),
   .transfer_buffer_out(transfer_buffer_out),
   .out_pin_0_out(out_pin_0_out), .out_pin_0_oe_out(out_pin_0_oe_out),
   .out_pin_1_out(out_pin_1_out), .out_pin_2_out(out_pin_2_out),
   .timer_mode_select_out(timer_mode_select_out),
   .counter_run_out(counter_run_out), .modulo_out(modulo_out)
);

// ==== tpd_lpf_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// external pull-up and low-pass filter on one open-drain pin
module tpd_lpf_model (
   // clock
   input wire logic core_clk_in,
   // pin drive
   input wire logic pin_oe_in,
   // filtered level, kept as a count of high cycles
   output int high_count_out
);
   // pull-up wins whenever the pin is released
   wire logic level = !pin_oe_in;
   initial high_count_out = 0;
   // integrator; a count avoids analog rounding in the compare
   always @(posedge core_clk_in) begin
      if (level) begin
         high_count_out <= high_count_out + 1;
      end
   end
endmodule

// ==== tpd_pwm_dac_test.sv ====
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the pwm dac block
module tpd_pwm_dac_test;
   // short dividers: high time per period is duty * 4 + 1 (or *40 + 10)
   localparam int FD = 4;
   localparam int SD = 40;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic ce_reset_in = 1'b0;
   logic halt_in = 1'b0;
   logic clock_stop_in = 1'b0;
   tpd_pkg::tpd_xfer_s xfer_in = '0;
   logic [2:0] port_latch_in = 3'h0;
   wire logic [15:0] transfer_buffer_out;
   wire logic [2:0] pin;
   wire logic [2:0] oe;
   wire logic timer_mode_select_out;
   wire logic counter_run_out;
   wire logic [8:0] modulo_out;
   int hc [3];
   int bad_count = 0;
   int samples_checked = 0;
   int cyc = 0;

   tpd_pwm_dac #(.FAST_DIV(FD), .SLOW_DIV(SD)) tpd_pwm_dac_inst (
      .core_clk_in(core_clk_in), .rst_in(rst_in),
      .ce_reset_in(ce_reset_in), .halt_in(halt_in),
      .clock_stop_in(clock_stop_in), .xfer_in(xfer_in),
      .transfer_buffer_out(transfer_buffer_out),
      .port_latch_in(port_latch_in),
      .out_pin_0_out(pin[0]), .out_pin_0_oe_out(oe[0]),
      .out_pin_1_out(pin[1]), .out_pin_1_oe_out(oe[1]),
      .out_pin_2_out(pin[2]), .out_pin_2_oe_out(oe[2]),
      .timer_mode_select_out(timer_mode_select_out),
      .counter_run_out(counter_run_out), .modulo_out(modulo_out));

   // one filter per pin
   for (genvar i = 0; i < 3; i++) begin : g_pin
      tpd_lpf_model tpd_lpf_model_inst (.core_clk_in(core_clk_in),
         .pin_oe_in(oe[i]), .high_count_out(hc[i]));
   end

   // clock and hang guard (whole run is about 27000 cycles)
   always #2.5 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         bad_count++;
         end_of_test();
      end
   end

   // ==========================================================
   // shared tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic xfer(input tpd_pkg::tpd_xfer_e k, input logic [7:0] a,
                       input logic [15:0] d);
      @(negedge core_clk_in);
      xfer_in = '{k, a, d};
      @(negedge core_clk_in);
      xfer_in.kind = tpd_pkg::TPD_XFER_NONE;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      xfer(tpd_pkg::TPD_XFER_WRITE, a, d);
   endtask

   // data stands from the edge after the request
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      xfer(tpd_pkg::TPD_XFER_READ, a, 16'h0);
      chk(transfer_buffer_out, exp);
   endtask

   // settle one period, then count high cycles over the next one
   task automatic meas(input int per, input int e0, input int e1,
                       input int e2);
      int c [3];
      repeat (per) @(negedge core_clk_in);
      c = hc;
      repeat (per) @(negedge core_clk_in);
      chk(16'(hc[0] - c[0]), 16'(e0));
      chk(16'(hc[1] - c[1]), 16'(e1));
      chk(16'(hc[2] - c[2]), 16'(e2));
   endtask

   task automatic end_of_test();
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      repeat (10) @(negedge core_clk_in);
      rst_in = 1'b0;
      rd(8'h44, 16'h01ff);
      rd(8'h46, 16'h01ff);
      rd(8'h28, 16'h0000);
      rd(8'h30, 16'h0000);
      chk({13'h0, pin}, 16'h0000);
      wr(8'h44, 16'hffff);
      rd(8'h44, 16'h01ff);
      wr(8'h27, 16'h000f);
      rd(8'h27, 16'h0007);
      // 8-bit fast, with ce reset and halt held throughout
      wr(8'h44, 16'h0000);
      wr(8'h45, 16'h0080);
      wr(8'h46, 16'h00ff);
      ce_reset_in = 1'b1;
      halt_in = 1'b1;
      meas(1024, 1, 513, 1021);
      ce_reset_in = 1'b0;
      halt_in = 1'b0;
      // counter clear restarts the channels at their staggered phases
      wr(8'h44, 16'h0080);
      wr(8'h46, 16'h0080);
      wr(8'h28, 16'h0001);
      repeat (2) @(negedge core_clk_in);
      chk({13'h0, pin}, 16'h0003);
      repeat (400) @(negedge core_clk_in);
      chk({13'h0, pin}, 16'h0005);
      wr(8'h46, 16'h00ff);
      // 9-bit fast
      wr(8'h26, 16'h0004);
      wr(8'h44, 16'h0100);
      wr(8'h45, 16'h01ff);
      meas(2048, 1025, 2045, 1021);
      // 8-bit slow
      wr(8'h26, 16'h0001);
      wr(8'h44, 16'h0040);
      wr(8'h45, 16'h00fe);
      meas(10240, 2570, 10170, 10210);
      // timer mode: latch drives pins, duties 0 and 1 keep eight bits
      port_latch_in = 3'h5;
      wr(8'h28, 16'h000e);
      rd(8'h28, 16'h000a);
      wr(8'h45, 16'h01ab);
      rd(8'h45, 16'h00ab);
      wr(8'h46, 16'h0155);
      rd(8'h46, 16'h0155);
      chk({7'h0, modulo_out}, 16'h0155);
      chk({13'h0, pin}, 16'h0005);
      chk({13'h0, oe}, 16'h0002);
      // clock stop for two cycles
      port_latch_in = 3'h3;
      @(negedge core_clk_in);
      clock_stop_in = 1'b1;
      repeat (2) @(negedge core_clk_in);
      clock_stop_in = 1'b0;
      @(negedge core_clk_in);
      chk({13'h0, pin}, 16'h0003);
      rd(8'h44, 16'h01ff);
      rd(8'h28, 16'h0000);
      end_of_test();
   end
endmodule
